// >>> ict_top.sv
// Interval counter and real-time timebase with its register file.
// What this block does
// R01: Interval match sets flag, requests enabled interrupt.
// R02: Software loads compare value, zero through 255.
// R03: Sub-second counter advances every 1/128 second.
// R04: Sub-second wraps after 127, carries into seconds.
// R05: Seconds wrap after 59, carry into minutes.
// R06: Minutes wrap after 59, carry into hours.
// R07: Hours wrap after 23, no further carry.
// R08: Time counts hold while time clock disabled.
// R09: Warm reset clears time only when clock disabled.
// R10: Power-on clears all time and compare registers.
// R11: Two-bit field picks interval counter timebase.
// R12: Single-shot match clears enable, else counter reloads.
// R13: Dropping interval enable stops and clears counter.
// R14: Time writes only when stopped; disabling clears all.
// R15: Time writes ignored while the clock runs.
`timescale 1ns/100ps
`include "ict_defs.svh"
module ict_top
   import ict_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `ICT_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sys_reset,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic interrupt_enable_priority_two,
   output logic interval_irq
);

   ict_time_if tif ();

   ict_time_chain #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_chain (
      .clk(clk),
      .reset_n(reset_n),
      .tif(tif)
   );

   logic time_clock_enable_q, time_clock_enable_d;
   logic interval_count_enable_q, interval_count_enable_d;
   logic sts_q, sts_d;
   logic flag_q, flag_d;
   ict_tb_t tb_q, tb_d;
   ict_byte_t interval_compare_value_q, interval_compare_value_d;
   ict_byte_t cnt_q, cnt_d;
   ict_ic_state_t st_q, st_d;
   ict_byte_t rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic wr_ctrl;
   logic wr_interval_compare_value;
   logic wr_time;
   logic tb_step;
   logic ic_match;
   ict_byte_t cnt_nxt;

   // Address decode of the register writes.
   assign wr_ctrl = sfr_wr && (sfr_addr == `ICT_ADDR_CTRL);
   assign wr_interval_compare_value = sfr_wr && (sfr_addr == `ICT_ADDR_INTERVAL_COMPARE_VALUE);
   assign wr_time = sfr_wr && (sfr_addr >= `ICT_ADDR_SUB)
      && (sfr_addr <= `ICT_ADDR_HOUR);

   // Selected counter step clocks the interval counter. [R11]
   always_comb
   begin
      case (tb_q)
         ICT_TB_SUB: tb_step = tif.step_sub;
         ICT_TB_SEC: tb_step = tif.step_sec;
         ICT_TB_MIN: tb_step = tif.step_min;
         ICT_TB_HOUR: tb_step = tif.step_hour;
         default: tb_step = 1'b0;
      endcase
   end

   // Control register, compare value and interval counter next state.
   always_comb
   begin
      time_clock_enable_d = time_clock_enable_q;
      interval_count_enable_d = interval_count_enable_q;
      sts_d = sts_q;
      flag_d = flag_q;
      tb_d = tb_q;
      interval_compare_value_d = interval_compare_value_q;
      cnt_d = cnt_q;
      st_d = st_q;
      ic_match = 1'b0;
      cnt_nxt = cnt_q + 8'h01;
      if (sys_reset)
      begin
         // The clock enable survives a warm reset when set. [R09]
         time_clock_enable_d = time_clock_enable_q;
         interval_count_enable_d = 1'b0;
         sts_d = 1'b0;
         flag_d = 1'b0;
         tb_d = ICT_TB_SUB;
         interval_compare_value_d = `ICT_RST_BYTE;
         cnt_d = `ICT_RST_BYTE;
         st_d = ICT_IC_OFF;
      end
      else
      begin
         if (wr_ctrl)
         begin
            time_clock_enable_d = sfr_wdata[`ICT_BIT_TIME_CLOCK_ENABLE];
            interval_count_enable_d = sfr_wdata[`ICT_BIT_INTERVAL_COUNT_ENABLE];
            sts_d = sfr_wdata[`ICT_BIT_STS];
            flag_d = sfr_wdata[`ICT_BIT_FLAG];
            tb_d = ict_tb_t'(sfr_wdata[`ICT_BIT_TB_HI:`ICT_BIT_TB_LO]);
         end
         if (wr_interval_compare_value)
         begin
            interval_compare_value_d = sfr_wdata; // [R02]
         end
         case (st_q)
            ICT_IC_OFF:
            begin
               // A disabled counter sits at zero. [R13]
               cnt_d = `ICT_RST_BYTE;
            end
            ICT_IC_RUN:
            begin
               if (tb_step)
               begin
                  if (cnt_nxt == interval_compare_value_q)
                  begin
                     ic_match = 1'b1;
                     cnt_d = `ICT_RST_BYTE; // [R12]
                  end
                  else
                  begin
                     cnt_d = cnt_nxt;
                  end
               end
            end
            default: cnt_d = `ICT_RST_BYTE;
         endcase
         if (ic_match)
         begin
            // A match outranks a clearing write in the same cycle. [R01]
            flag_d = 1'b1;
            if (sts_q)
            begin
               interval_count_enable_d = 1'b0; // [R12]
            end
         end
         st_d = interval_count_enable_d ? ICT_IC_RUN : ICT_IC_OFF;
         if (!interval_count_enable_d)
         begin
            cnt_d = `ICT_RST_BYTE; // [R13]
         end
      end
   end

   // Power-on clears every register, the clock enable included. [R10]
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         time_clock_enable_q <= 1'b0;
         interval_count_enable_q <= 1'b0;
         sts_q <= 1'b0;
         flag_q <= 1'b0;
         tb_q <= ICT_TB_SUB;
         interval_compare_value_q <= `ICT_RST_BYTE;
         cnt_q <= `ICT_RST_BYTE;
         st_q <= ICT_IC_OFF;
      end
      else
      begin
         time_clock_enable_q <= time_clock_enable_d;
         interval_count_enable_q <= interval_count_enable_d;
         sts_q <= sts_d;
         flag_q <= flag_d;
         tb_q <= tb_d;
         interval_compare_value_q <= interval_compare_value_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
      end
   end

   // Time chain control. Disabling the clock clears the chain once, so
   // software may then load a fresh time while it stays stopped.
   assign tif.run = time_clock_enable_q; // [R08]
   assign tif.clear = (sys_reset && !time_clock_enable_q) || (time_clock_enable_q && !time_clock_enable_d); // [R14]
   assign tif.wr_en = wr_time && !time_clock_enable_q && !sys_reset; // [R15]
   assign tif.wr_sel = sfr_addr;
   assign tif.wr_data = sfr_wdata;

   // Read data and interrupt request, both registered.
   always_comb
   begin
      rdata_d = rdata_q;
      irq_d = flag_q && interrupt_enable_priority_two; // [R01]
      if (sfr_rd)
      begin
         case (sfr_addr)
            `ICT_ADDR_CTRL: rdata_d = {2'b00, tb_q, sts_q, flag_q, interval_count_enable_q,
               time_clock_enable_q};
            `ICT_ADDR_SUB: rdata_d = tif.sub;
            `ICT_ADDR_SEC: rdata_d = tif.sec;
            `ICT_ADDR_MIN: rdata_d = tif.min;
            `ICT_ADDR_HOUR: rdata_d = tif.hour;
            `ICT_ADDR_INTERVAL_COMPARE_VALUE: rdata_d = interval_compare_value_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Output flops.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign interval_irq = irq_q;

   // A match raises the flag and, when enabled, the request. The request
   // follows the enable as it stood one edge after the match.
   AST_MATCH_FLAG: assert property ( // [R01]
      @(posedge clk) disable iff (!reset_n)
      ic_match |=> flag_q ##1
      interval_irq == $past(interrupt_enable_priority_two))
      else $error("Interval match did not raise flag or interrupt.");
   AST_IRQ_GATE: assert property ( // [R01]
      @(posedge clk) disable iff (!reset_n)
      !interrupt_enable_priority_two |=> !interval_irq)
      else $error("Interrupt raised while its enable was low.");
   AST_INTERVAL_COMPARE_VALUE_LOAD: assert property ( // [R02]
      @(posedge clk) disable iff (!reset_n)
      wr_interval_compare_value && !sys_reset |=> interval_compare_value_q == $past(sfr_wdata))
      else $error("Compare value not loaded by write.");
   AST_HOLD_STOPPED: assert property ( // [R08]
      @(posedge clk) disable iff (!reset_n)
      !time_clock_enable_q && !tif.wr_en && !tif.clear |=> $stable(tif.sub)
      && $stable(tif.hour))
      else $error("Time counts moved while the clock was disabled.");
   // A seconds step may still fall on the reset cycle of a running clock.
   AST_WARM_KEEP: assert property ( // [R09]
      @(posedge clk) disable iff (!reset_n)
      sys_reset && time_clock_enable_q && !tif.step_sec |=> time_clock_enable_q
      && tif.sec == $past(tif.sec))
      else $error("Warm reset disturbed a running clock.");
   AST_WARM_CLEAR: assert property ( // [R09]
      @(posedge clk) disable iff (!reset_n)
      sys_reset && !time_clock_enable_q |=> tif.sub == 8'h00 && tif.min == 8'h00
      && interval_compare_value_q == 8'h00)
      else $error("Warm reset with clock disabled left a value.");
   AST_WARM_CTRL: assert property ( // [R09]
      @(posedge clk) disable iff (!reset_n)
      sys_reset |=> !interval_count_enable_q && !flag_q && interval_compare_value_q == 8'h00)
      else $error("Warm reset left interval state set.");
   // A control write may legally clear the counter, so it is left out.
   AST_TB_SELECT: assert property ( // [R11]
      @(posedge clk) disable iff (!reset_n)
      st_q == ICT_IC_RUN && tb_q == ICT_TB_SEC && !tif.step_sec
      && !sys_reset && !wr_ctrl |=> cnt_q == $past(cnt_q))
      else $error("Interval counter stepped without its timebase.");
   AST_SINGLE_SHOT: assert property ( // [R12]
      @(posedge clk) disable iff (!reset_n)
      ic_match && sts_q |=> !interval_count_enable_q ##1 cnt_q == 8'h00)
      else $error("Single-shot match did not stop the counter.");
   AST_RELOAD: assert property ( // [R12]
      @(posedge clk) disable iff (!reset_n)
      ic_match && !sts_q && !wr_ctrl |=> interval_count_enable_q && cnt_q == 8'h00)
      else $error("Periodic match did not reload the counter.");
   AST_IC_CLEARED: assert property ( // [R13]
      @(posedge clk) disable iff (!reset_n)
      !interval_count_enable_q |-> cnt_q == 8'h00)
      else $error("Interval counter not zero while disabled.");
   AST_OFF_NO_MATCH: assert property ( // [R13]
      @(posedge clk) disable iff (!reset_n)
      st_q == ICT_IC_OFF |-> !ic_match)
      else $error("Disabled interval counter produced a match.");
   AST_DISABLE_CLEAR: assert property ( // [R14]
      @(posedge clk) disable iff (!reset_n)
      time_clock_enable_q && !time_clock_enable_d |=> tif.sub == 8'h00 && tif.sec == 8'h00
      && tif.min == 8'h00 && tif.hour == 8'h00)
      else $error("Disabling the clock did not clear the time.");
   AST_RUN_WRITE: assert property ( // [R15]
      @(posedge clk) disable iff (!reset_n)
      time_clock_enable_q && wr_time && !tif.step_sub |=> $stable(tif.sub)
      && $stable(tif.min))
      else $error("Time write took effect while running.");

endmodule : ict_top

// >>> ict_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH

// Special-function register addresses.
`define ICT_ADDR_CTRL 8'ha1
`define ICT_ADDR_SUB 8'ha2
`define ICT_ADDR_SEC 8'ha3
`define ICT_ADDR_MIN 8'ha4
`define ICT_ADDR_HOUR 8'ha5
`define ICT_ADDR_INTERVAL_COMPARE_VALUE 8'ha6

// Control register field positions.
`define ICT_BIT_TIME_CLOCK_ENABLE 0
`define ICT_BIT_INTERVAL_COUNT_ENABLE 1
`define ICT_BIT_FLAG 2
`define ICT_BIT_STS 3
`define ICT_BIT_TB_LO 4
`define ICT_BIT_TB_HI 5

// Reset values.
`define ICT_RST_BYTE 8'h00
`define ICT_RST_TB 2'h0

// Counter limits.
`define ICT_SUB_MAX 8'h7f
`define ICT_SEC_MAX 8'h3b
`define ICT_MIN_MAX 8'h3b
`define ICT_HOUR_MAX 8'h17

// Timing: one sub-second step is 1/128 s, the clock period is 10 ns.
`define ICT_TICK_NS 7812500
`define ICT_CLK_NS 10
`define ICT_TICK_CYCLES (`ICT_TICK_NS / `ICT_CLK_NS)

`endif

// >>> ict_pkg.sv
// Types shared by the interval counter and timebase modules.
package ict_pkg;

   typedef logic [7:0] ict_byte_t;

   // Interval counter state, one-hot.
   typedef enum logic [1:0]
   {
      ICT_IC_OFF = 2'b01,
      ICT_IC_RUN = 2'b10
   } ict_ic_state_t;

   // Interval timebase selection.
   typedef enum logic [1:0]
   {
      ICT_TB_SUB = 2'b00,
      ICT_TB_SEC = 2'b01,
      ICT_TB_MIN = 2'b10,
      ICT_TB_HOUR = 2'b11
   } ict_tb_t;

   // Wrapping increment shared by all time counters.
   function automatic ict_byte_t ict_step(input ict_byte_t val,
                                          input ict_byte_t max);
      if (val >= max)
      begin
         return 8'h00;
      end
      return val + 8'h01;
   endfunction : ict_step

endpackage : ict_pkg

// >>> ict_time_if.sv
// Bundle between the control logic and the cascaded time counters.
`timescale 1ns/100ps
interface ict_time_if;
   import ict_pkg::*;
   logic run;
   logic clear;
   logic wr_en;
   logic [7:0] wr_sel;
   ict_byte_t wr_data;
   ict_byte_t sub;
   ict_byte_t sec;
   ict_byte_t min;
   ict_byte_t hour;
   logic step_sub;
   logic step_sec;
   logic step_min;
   logic step_hour;

   modport chain
   (
      input run, clear, wr_en, wr_sel, wr_data,
      output sub, sec, min, hour, step_sub, step_sec, step_min, step_hour
   );
   modport ctrl
   (
      output run, clear, wr_en, wr_sel, wr_data,
      input sub, sec, min, hour, step_sub, step_sec, step_min, step_hour
   );
endinterface : ict_time_if

// >>> ict_time_chain.sv
// Prescaler and cascaded sub-second, second, minute and hour counters.
`timescale 1ns/100ps
`include "ict_defs.svh"
module ict_time_chain
   import ict_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `ICT_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic reset_n,
   ict_time_if.chain tif
);

   logic [19:0] pre_q;
   logic [19:0] pre_d;
   ict_byte_t sub_q, sub_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
   logic st_sub, st_sec, st_min, st_hour;

   // Step pulses ripple down the chain in the same cycle as the tick.
   always_comb
   begin
      pre_d = pre_q;
      sub_d = sub_q;
      sec_d = sec_q;
      min_d = min_q;
      hour_d = hour_q;
      st_sub = 1'b0;
      st_sec = 1'b0;
      st_min = 1'b0;
      st_hour = 1'b0;
      if (tif.clear)
      begin
         // Prescaler and all counts return to zero. [R14] [R09]
         pre_d = 20'h00000;
         sub_d = `ICT_RST_BYTE;
         sec_d = `ICT_RST_BYTE;
         min_d = `ICT_RST_BYTE;
         hour_d = `ICT_RST_BYTE;
      end
      else if (tif.run)
      begin
         // Counting only while the time clock is enabled. [R08] [R03]
         if (pre_q >= 20'(TICK_CYCLES - 1))
         begin
            pre_d = 20'h00000;
            st_sub = 1'b1;
         end
         else
         begin
            pre_d = pre_q + 20'h00001;
         end
         if (st_sub)
         begin
            sub_d = ict_step(sub_q, `ICT_SUB_MAX); // [R04]
            st_sec = (sub_q == `ICT_SUB_MAX);
         end
         if (st_sec)
         begin
            sec_d = ict_step(sec_q, `ICT_SEC_MAX); // [R05]
            st_min = (sec_q == `ICT_SEC_MAX);
         end
         if (st_min)
         begin
            min_d = ict_step(min_q, `ICT_MIN_MAX); // [R06]
            st_hour = (min_q == `ICT_MIN_MAX);
         end
         if (st_hour)
         begin
            hour_d = ict_step(hour_q, `ICT_HOUR_MAX); // [R07]
         end
      end
      else if (tif.wr_en)
      begin
         // Software loads the time only while stopped.
         case (tif.wr_sel)
            `ICT_ADDR_SUB: sub_d = tif.wr_data;
            `ICT_ADDR_SEC: sec_d = tif.wr_data;
            `ICT_ADDR_MIN: min_d = tif.wr_data;
            `ICT_ADDR_HOUR: hour_d = tif.wr_data;
            default: sub_d = sub_q;
         endcase
      end
   end

   // Power-on clears everything regardless of the enable. [R10]
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_q <= 20'h00000;
         sub_q <= `ICT_RST_BYTE;
         sec_q <= `ICT_RST_BYTE;
         min_q <= `ICT_RST_BYTE;
         hour_q <= `ICT_RST_BYTE;
      end
      else
      begin
         pre_q <= pre_d;
         sub_q <= sub_d;
         sec_q <= sec_d;
         min_q <= min_d;
         hour_q <= hour_d;
      end
   end

   assign tif.sub = sub_q;
   assign tif.sec = sec_q;
   assign tif.min = min_q;
   assign tif.hour = hour_q;
   assign tif.step_sub = st_sub;
   assign tif.step_sec = st_sec;
   assign tif.step_min = st_min;
   assign tif.step_hour = st_hour;

   // Wrap checks on each stage of the cascade and an advance check on the sub-second stage.
   AST_SUB_WRAP: assert property ( // [R04]
      @(posedge clk) disable iff (!reset_n)
      st_sub && !tif.clear && sub_q == `ICT_SUB_MAX |=> sub_q == 8'h00
      && sec_q == ict_step($past(sec_q), `ICT_SEC_MAX))
      else $error("Sub-second wrap did not carry into seconds.");
   AST_SUB_ADV: assert property ( // [R03]
      @(posedge clk) disable iff (!reset_n)
      st_sub && sub_q < `ICT_SUB_MAX |=> sub_q == $past(sub_q) + 8'h01)
      else $error("Sub-second counter did not advance on tick.");
   AST_SEC_WRAP: assert property ( // [R05]
      @(posedge clk) disable iff (!reset_n)
      st_sec && sec_q == `ICT_SEC_MAX |=> sec_q == 8'h00)
      else $error("Seconds did not wrap after 59.");
   AST_MIN_WRAP: assert property ( // [R06]
      @(posedge clk) disable iff (!reset_n)
      st_min && min_q == `ICT_MIN_MAX |=> min_q == 8'h00)
      else $error("Minutes did not wrap after 59.");
   AST_HOUR_WRAP: assert property ( // [R07]
      @(posedge clk) disable iff (!reset_n)
      st_hour && hour_q == `ICT_HOUR_MAX |=> hour_q == 8'h00)
      else $error("Hours did not wrap after 23.");

endmodule : ict_time_chain

// >>> ict_tb.sv
// Self-checking testbench for the interval counter and timebase block.
`timescale 1ns/100ps
`include "ict_defs.svh"
module tb;
   import ict_pkg::*;
   // Short prescale so one 1/128 s step lasts four clocks.
   localparam int unsigned TK = 4;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic sys_reset = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic irq_en = 1'b1;
   logic interval_irq;
   int miscompares = 0;
   int n_compared = 0;
   int cyc;
   int i;
   // Preloads of sub-second, seconds and minutes for each timebase, and
   // the number of 1/128 s steps until the selected unit first steps.
   ict_byte_t pre [4][3] = '{'{8'h00, 8'h00, 8'h00},
      '{8'h70, 8'h00, 8'h00}, '{8'h70, 8'h3a, 8'h00},
      '{8'h70, 8'h3a, 8'h3b}};
   int tks [4] = '{1, 16, 144, 144};

   ict_top #(.TICK_CYCLES(TK)) DUT
   (
      .clk(clk),
      .reset_n(reset_n),
      .sys_reset(sys_reset),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata),
      .interrupt_enable_priority_two(irq_en),
      .interval_irq(interval_irq)
   );

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // Case equality so that an unknown never passes for a match.
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   // One-cycle write strobe; the leading wait keeps strobes apart.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr

   // Read data is registered at the read edge, so look half a cycle on.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      check(sfr_rdata, exp);
   endtask : rd

   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (interval_irq !== 1'b1 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_irq

   // The prescaler phase is not known exactly, so allow some slack.
   task automatic in_win(input int n, input int t);
      check({7'h00, n >= TK * t - 4 && n <= TK * t + 6}, 8'h01);
   endtask : in_win

   task automatic pulse_sys;
      @(negedge clk);
      sys_reset = 1'b1;
      @(negedge clk);
      sys_reset = 1'b0;
   endtask : pulse_sys

   // Main sequence of tests.
   initial
   begin
      idle(8);
      reset_n = 1'b1;
      for (i = 8'ha0; i <= 8'ha7; i++)
      begin
         rd(8'(i), 8'h00);
      end
      wr(`ICT_ADDR_CTRL, 8'hc0);
      rd(`ICT_ADDR_CTRL, 8'h00);
      // Software may set the flag itself; the request must follow it.
      wr(`ICT_ADDR_CTRL, 8'h04);
      rd(`ICT_ADDR_CTRL, 8'h04);
      check({7'h00, interval_irq}, 8'h01);
      $display("test reset values done");
      wr(`ICT_ADDR_SUB, 8'h7f);
      wr(`ICT_ADDR_SEC, 8'h3b);
      wr(`ICT_ADDR_MIN, 8'h3b);
      wr(`ICT_ADDR_HOUR, 8'h17);
      idle(50);
      rd(`ICT_ADDR_HOUR, 8'h17);
      rd(`ICT_ADDR_SUB, 8'h7f);
      wr(`ICT_ADDR_CTRL, 8'h01);
      idle(8);
      rd(`ICT_ADDR_HOUR, 8'h00);
      rd(`ICT_ADDR_MIN, 8'h00);
      rd(`ICT_ADDR_SEC, 8'h00);
      wr(`ICT_ADDR_SEC, 8'h05);
      rd(`ICT_ADDR_SEC, 8'h00);
      wr(`ICT_ADDR_CTRL, 8'h00);
      rd(`ICT_ADDR_SUB, 8'h00);
      $display("test wrap and write lock done");
      wr(`ICT_ADDR_CTRL, 8'h01);
      idle(500);
      rd(`ICT_ADDR_SEC, 8'h00);
      idle(25);
      rd(`ICT_ADDR_SEC, 8'h01);
      $display("test step rate done");
      wr(`ICT_ADDR_CTRL, 8'h00);
      wr(`ICT_ADDR_SEC, 8'h10);
      pulse_sys();
      rd(`ICT_ADDR_SEC, 8'h00);
      wr(`ICT_ADDR_SEC, 8'h10);
      wr(`ICT_ADDR_CTRL, 8'h01);
      pulse_sys();
      rd(`ICT_ADDR_SEC, 8'h10);
      rd(`ICT_ADDR_CTRL, 8'h01);
      $display("test warm reset done");
      for (i = 0; i < 4; i++)
      begin
         wr(`ICT_ADDR_CTRL, 8'h00);
         wr(`ICT_ADDR_SUB, pre[i][0]);
         wr(`ICT_ADDR_SEC, pre[i][1]);
         wr(`ICT_ADDR_MIN, pre[i][2]);
         wr(`ICT_ADDR_INTERVAL_COMPARE_VALUE, 8'h01);
         wr(`ICT_ADDR_CTRL, 8'h03 | 8'(i << 4));
         wait_irq(TK * tks[i] + 20, cyc);
         in_win(cyc, tks[i]);
         rd(`ICT_ADDR_CTRL, 8'h07 | 8'(i << 4));
      end
      $display("test timebase select done");
      wr(`ICT_ADDR_CTRL, 8'h00);
      wr(`ICT_ADDR_INTERVAL_COMPARE_VALUE, 8'h02);
      wr(`ICT_ADDR_CTRL, 8'h03);
      wait_irq(40, cyc);
      in_win(cyc, 2);
      wr(`ICT_ADDR_CTRL, 8'h03);
      idle(2);
      check({7'h00, interval_irq}, 8'h00);
      wait_irq(12, cyc);
      check({7'h00, interval_irq}, 8'h01);
      // Single shot with the interrupt enable low: flag only, no request.
      wr(`ICT_ADDR_CTRL, 8'h00);
      irq_en = 1'b0;
      wr(`ICT_ADDR_CTRL, 8'h0b);
      idle(TK * 2 + 8);
      rd(`ICT_ADDR_CTRL, 8'h0d);
      check({7'h00, interval_irq}, 8'h00);
      irq_en = 1'b1;
      idle(2);
      check({7'h00, interval_irq}, 8'h01);
      $display("test reload and single shot done");
      wr(`ICT_ADDR_CTRL, 8'h00);
      wr(`ICT_ADDR_INTERVAL_COMPARE_VALUE, 8'h05);
      wr(`ICT_ADDR_CTRL, 8'h03);
      idle(TK * 3);
      wr(`ICT_ADDR_CTRL, 8'h01);
      wr(`ICT_ADDR_CTRL, 8'h03);
      wait_irq(60, cyc);
      in_win(cyc, 5);
      $display("test interval enable clear done");
      wr(`ICT_ADDR_INTERVAL_COMPARE_VALUE, 8'hff);
      rd(`ICT_ADDR_INTERVAL_COMPARE_VALUE, 8'hff);
      wr(`ICT_ADDR_CTRL, 8'h01);
      @(negedge clk);
      reset_n = 1'b0;
      idle(2);
      reset_n = 1'b1;
      for (i = 8'ha1; i <= 8'ha6; i++)
      begin
         rd(8'(i), 8'h00);
      end
      $display("test power-on reset done");
      report_and_stop();
   end

   // Cuts a hang short; the tests need roughly 21 us.
   initial
   begin
      #100us;
      miscompares++;
      $display("watchdog expired at %0t", $time);
      report_and_stop();
   end
endmodule : tb
